/* rtl/twm_master_engine.sv */
// Two-wire bus master engine with APB register access
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
`include "twm_map.svh"

module twm_master_engine #(
  parameter int BRG_W = 12
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             scl_out,
  output logic             scl_oe,
  output logic             sda_out,
  output logic             sda_oe,
  input  wire logic        sleep_mode,
  input  wire logic        cpu_idle,
  output logic             master_event
);

  function automatic logic reg_hit(input logic [11:0] a,
                                   input logic [9:0]  idx);
    reg_hit = (a[11:2] == idx) && (a[1:0] == 2'b00);
  endfunction

  function automatic logic [4:0] req_of(input twm_pkg::twm_state_type s);
    req_of = 5'h00;
    case (s)
      twm_pkg::TWM_START:   req_of[`TWM_CON_SEN]   = 1'b1;
      twm_pkg::TWM_RESTART: req_of[`TWM_CON_RESTART_REQUEST]  = 1'b1;
      twm_pkg::TWM_STOP:    req_of[`TWM_CON_PEN]   = 1'b1;
      twm_pkg::TWM_RX:      req_of[`TWM_CON_MASTER_RECEIVE_ENABLE]  = 1'b1;
      twm_pkg::TWM_ACK:     req_of[`TWM_CON_ACK_SEQUENCE_ENABLE] = 1'b1;
      default:              req_of = 5'h00;
    endcase
  endfunction

  twm_pkg::twm_state_type state;
  twm_pkg::twm_state_type next_state;
  twm_pkg::twm_line_type  sync1;
  twm_pkg::twm_line_type  sync2;
  twm_pkg::twm_line_type  sync3;
  twm_pkg::twm_line_type  bus;
  twm_pkg::twm_line_type  bus_prev;
  twm_pkg::twm_line_type  drive;
  twm_pkg::twm_line_type  next_drive;
  logic [1:0]        phase;
  logic [1:0]        next_phase;
  logic [3:0]        bit_cnt;
  logic [3:0]        next_bit;
  logic [7:0]        tx_shift;
  logic [7:0]        next_tx_shift;
  logic [7:0]        receive_shift_reg;
  logic [BRG_W-1:0]  bit_rate_counter;
  logic              scl_wait;
  logic              load;
  logic              next_wait;
  logic              done;
  logic [15:0]       receive_byte;
  logic [15:0]       transmit_byte;
  logic [15:0]       bit_rate_reload;
  logic [15:0]       port_control;
  logic [15:0]       own_slave_address;
  logic              ack_status;
  logic              collision_flag;
  logic              stop_seen_flag;
  logic              start_seen_flag;
  logic              receive_buffer_full;
  logic              transmit_buffer_full;
  logic              tx_go;
  logic              lost_arb;
  logic              active;
  logic              abort;
  logic              tick;
  logic              check;
  logic              collide;
  logic              port_ready;
  logic              rx_sample;
  logic              start_seen;
  logic              stop_seen;
  logic              mapped;
  logic              wr;
  logic              rd;
  logic [15:0]       rd_value;
  logic [15:0]       port_status;

  // Open-drain lines: only ever pull low
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe  = drive.scl;
  assign sda_oe  = drive.sda;

  assign mapped = reg_hit(paddr, `TWM_IDX_RCV) | reg_hit(paddr, `TWM_IDX_TRN)
                | reg_hit(paddr, `TWM_IDX_BRG) | reg_hit(paddr, `TWM_IDX_CON)
                | reg_hit(paddr, `TWM_IDX_STAT)
                | reg_hit(paddr, `TWM_IDX_ADD);
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign wr      = psel & penable & pwrite & mapped;
  assign rd      = psel & penable & ~pwrite & mapped;

  assign abort  = ~port_control[`TWM_CON_EN] | sleep_mode;
  assign active = ~abort & ~(cpu_idle & port_control[`TWM_CON_SIDL]);
  assign tick   = active && (state != twm_pkg::TWM_IDLE) && !scl_wait
                  && (bit_rate_counter == '0);
  assign port_ready = (state == twm_pkg::TWM_IDLE) && !tx_go
                      && (port_control[`TWM_CON_REQ_HI:0] == 5'h00);
  assign rx_sample = active && (state == twm_pkg::TWM_RX) && (phase == 2'd1)
                     && scl_wait && bus.scl;
  assign start_seen = bus.scl && bus_prev.scl && bus_prev.sda && !bus.sda;
  assign stop_seen  = bus.scl && bus_prev.scl && !bus_prev.sda && bus.sda;

  // Checked at the end of a high phase so the line has settled
  always_comb begin
    case (state)
      twm_pkg::TWM_TX:      check = (phase == 2'd1)
                                    && (bit_cnt != `TWM_LAST_TX_BIT);
      twm_pkg::TWM_ACK:     check = (phase == 2'd1);
      twm_pkg::TWM_START:   check = (phase == 2'd0);
      twm_pkg::TWM_RESTART: check = (phase == 2'd1);
      twm_pkg::TWM_STOP:    check = (phase == 2'd2);
      default:              check = 1'b0;
    endcase
  end
  assign collide = tick && check && !drive.sda && !bus.sda;

  always_comb begin
    next_state    = state;
    next_phase    = phase;
    next_bit      = bit_cnt;
    next_drive    = drive;
    next_tx_shift = tx_shift;
    load          = 1'b0;
    next_wait     = 1'b0;
    done          = 1'b0;
    if (abort) begin
      next_state = twm_pkg::TWM_IDLE;
      next_drive = '{scl: 1'b0, sda: 1'b0};
    end else if (active) begin
      if (collide) begin
        next_state = twm_pkg::TWM_IDLE;
        next_drive = '{scl: 1'b0, sda: 1'b0};
      end else begin
        case (state)
          twm_pkg::TWM_IDLE: begin
            next_phase = 2'd0;
            next_bit   = 4'd0;
            load       = 1'b1;
            if (port_control[`TWM_CON_SEN]) begin
              next_state = twm_pkg::TWM_START;
              next_drive = '{scl: 1'b0, sda: 1'b0};
              next_wait  = 1'b1;
            end else if (port_control[`TWM_CON_RESTART_REQUEST]) begin
              next_state = twm_pkg::TWM_RESTART;
              next_drive = '{scl: 1'b1, sda: 1'b0};
            end else if (port_control[`TWM_CON_PEN]) begin
              next_state = twm_pkg::TWM_STOP;
              next_drive = '{scl: 1'b1, sda: 1'b1};
            end else if (port_control[`TWM_CON_MASTER_RECEIVE_ENABLE]) begin
              next_state = twm_pkg::TWM_RX;
              next_drive = '{scl: 1'b1, sda: 1'b0};
            end else if (port_control[`TWM_CON_ACK_SEQUENCE_ENABLE]) begin
              next_state = twm_pkg::TWM_ACK;
              next_drive = '{scl: 1'b1,
                             sda: ~port_control[`TWM_CON_ACK_VALUE]};
            end else if (tx_go) begin
              next_state    = twm_pkg::TWM_TX;
              next_tx_shift = transmit_byte[7:0];
              next_drive    = '{scl: 1'b1, sda: ~transmit_byte[7]};
            end else begin
              load = 1'b0;
            end
          end
          twm_pkg::TWM_START: if (tick) begin
            if (phase == 2'd0) begin
              next_drive.sda = 1'b1;
              next_phase     = 2'd1;
              load           = 1'b1;
            end else begin
              next_drive.scl = 1'b1;
              done           = 1'b1;
            end
          end
          twm_pkg::TWM_RESTART, twm_pkg::TWM_STOP: if (tick) begin
            load = 1'b1;
            next_phase = phase + 2'd1;
            case (phase)
              2'd0: begin
                next_drive.scl = 1'b0;
                next_wait      = 1'b1;
              end
              2'd1: next_drive.sda = (state == twm_pkg::TWM_RESTART);
              default: begin
                next_drive.scl = (state == twm_pkg::TWM_RESTART);
                done           = 1'b1;
              end
            endcase
          end
          twm_pkg::TWM_TX, twm_pkg::TWM_RX, twm_pkg::TWM_ACK: if (tick) begin
            load = 1'b1;
            if (phase == 2'd0) begin
              next_drive.scl = 1'b0;
              next_wait      = 1'b1;
              next_phase     = 2'd1;
            end else begin
              next_drive.scl = 1'b1;
              next_phase     = 2'd0;
              next_bit       = bit_cnt + 4'd1;
              next_tx_shift  = {tx_shift[6:0], 1'b1};
              if (state == twm_pkg::TWM_TX) begin
                next_drive.sda = ~tx_shift[6];
              end else begin
                next_drive.sda = 1'b0;
              end
              if ((state == twm_pkg::TWM_ACK)
                  || (state == twm_pkg::TWM_TX
                      && bit_cnt == `TWM_LAST_TX_BIT)
                  || (state == twm_pkg::TWM_RX
                      && bit_cnt == `TWM_LAST_RX_BIT)) begin
                done = 1'b1;
              end
            end
          end
          default: next_state = twm_pkg::TWM_IDLE;
        endcase
        if (done) begin
          next_state = twm_pkg::TWM_IDLE;
          load       = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state    <= twm_pkg::TWM_IDLE;
      phase    <= 2'd0;
      bit_cnt  <= 4'd0;
      drive    <= '{scl: 1'b0, sda: 1'b0};
      tx_shift <= 8'h00;
    end else begin
      state    <= next_state;
      phase    <= next_phase;
      bit_cnt  <= next_bit;
      drive    <= next_drive;
      tx_shift <= next_tx_shift;
    end
  end

  // Bit-rate counter; an illegal reload of 0 or 1 just runs fast
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_rate_counter <= '0;
      scl_wait         <= 1'b0;
    end else if (active) begin
      if (load) begin
        bit_rate_counter <= bit_rate_reload[BRG_W-1:0];
        scl_wait         <= next_wait;
      end else if (scl_wait) begin
        if (bus.scl) begin
          bit_rate_counter <= bit_rate_reload[BRG_W-1:0];
          scl_wait         <= 1'b0;
        end
      end else if (bit_rate_counter != '0) begin
        bit_rate_counter <= bit_rate_counter - 1'b1;
      end
    end
  end

  // Lines arrive from outside: three stages, change once 2 and 3 agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1    <= '{scl: 1'b1, sda: 1'b1};
      sync2    <= '{scl: 1'b1, sda: 1'b1};
      sync3    <= '{scl: 1'b1, sda: 1'b1};
      bus      <= '{scl: 1'b1, sda: 1'b1};
      bus_prev <= '{scl: 1'b1, sda: 1'b1};
    end else begin
      sync1    <= '{scl: scl_in, sda: sda_in};
      sync2    <= sync1;
      sync3    <= sync2;
      bus_prev <= bus;
      if (sync2.scl == sync3.scl) begin
        bus.scl <= sync3.scl;
      end
      if (sync2.sda == sync3.sda) begin
        bus.sda <= sync3.sda;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      receive_shift_reg <= 8'h00;
    end else if (rx_sample) begin
      receive_shift_reg <= {receive_shift_reg[6:0], bus.sda};
    end
  end

  // Configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_rate_reload   <= `TWM_RST_BRG;
      own_slave_address <= `TWM_RST_ADD;
      port_control      <= `TWM_RST_CON;
    end else begin
      if (wr && reg_hit(paddr, `TWM_IDX_BRG)) begin
        bit_rate_reload <= pwdata[15:0];
      end
      if (wr && reg_hit(paddr, `TWM_IDX_ADD)) begin
        own_slave_address <= pwdata[15:0] & `TWM_ADD_MASK;
      end
      if (wr && reg_hit(paddr, `TWM_IDX_CON)) begin
        port_control[15:`TWM_CON_REQ_HI+1] <=
          pwdata[15:`TWM_CON_REQ_HI+1]
          & 11'(`TWM_CON_MASK >> (`TWM_CON_REQ_HI + 1));
      end
      // requests only when idle
      // Busy-time writes must never mask the hardware clear
      if (wr && reg_hit(paddr, `TWM_IDX_CON) && port_ready) begin
        port_control[`TWM_CON_REQ_HI:0] <= pwdata[`TWM_CON_REQ_HI:0];
      end else if (done || collide
                   || (abort && state != twm_pkg::TWM_IDLE)) begin
        port_control[`TWM_CON_REQ_HI:0] <=
          port_control[`TWM_CON_REQ_HI:0] & ~req_of(state);
      end
    end
  end

  // Data and status flags; hardware set wins over software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      transmit_byte        <= `TWM_RST_TRN;
      receive_byte         <= `TWM_RST_RCV;
      transmit_buffer_full <= 1'b0;
      receive_buffer_full  <= 1'b0;
      tx_go                <= 1'b0;
      ack_status           <= 1'b0;
      collision_flag       <= 1'b0;
    end else begin
      if (wr && reg_hit(paddr, `TWM_IDX_TRN) && port_ready) begin
        transmit_byte        <= {8'h00, pwdata[7:0]};
        transmit_buffer_full <= 1'b1;
        tx_go                <= 1'b1;
      end else if (state == twm_pkg::TWM_TX && (done || collide || abort))
      begin
        transmit_buffer_full <= 1'b0;
      end
      if (state != twm_pkg::TWM_IDLE || abort) begin
        tx_go <= 1'b0;
      end
      if (tick && state == twm_pkg::TWM_TX && phase == 2'd1
          && bit_cnt == `TWM_LAST_TX_BIT) begin
        ack_status <= bus.sda;
      end
      if (done && state == twm_pkg::TWM_RX) begin
        receive_byte        <= {8'h00, receive_shift_reg};
        receive_buffer_full <= 1'b1;
      end else if (rd && reg_hit(paddr, `TWM_IDX_RCV)) begin
        receive_buffer_full <= 1'b0;
      end
      if (collide) begin
        collision_flag <= 1'b1;
      end else if (wr && reg_hit(paddr, `TWM_IDX_STAT)
                   && !pwdata[`TWM_ST_BCL]) begin
        collision_flag <= 1'b0;
      end
    end
  end

  // Bus watch and event pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_seen_flag <= 1'b0;
      stop_seen_flag  <= 1'b0;
      lost_arb        <= 1'b0;
      master_event    <= 1'b0;
    end else begin
      if (!port_control[`TWM_CON_EN]) begin
        start_seen_flag <= 1'b0;
        stop_seen_flag  <= 1'b0;
      end else if (start_seen) begin
        start_seen_flag <= 1'b1;
        stop_seen_flag  <= 1'b0;
      end else if (stop_seen) begin
        start_seen_flag <= 1'b0;
        stop_seen_flag  <= 1'b1;
      end
      if (collide) begin
        lost_arb <= 1'b1;
      end else if (stop_seen || abort) begin
        lost_arb <= 1'b0;
      end
      master_event <= done | collide | (lost_arb & stop_seen & ~abort);
    end
  end

  always_comb begin
    port_status                 = 16'h0000;
    port_status[`TWM_ST_ACKSTAT] = ack_status;
    port_status[`TWM_ST_MASTER_TX_ACTIVE]  = (state == twm_pkg::TWM_TX);
    port_status[`TWM_ST_BCL]     = collision_flag;
    port_status[`TWM_ST_P]       = stop_seen_flag;
    port_status[`TWM_ST_S]       = start_seen_flag;
    port_status[`TWM_ST_RBF]     = receive_buffer_full;
    port_status[`TWM_ST_TBF]     = transmit_buffer_full;
    rd_value = 16'h0000;
    if (reg_hit(paddr, `TWM_IDX_RCV))  rd_value = receive_byte;
    if (reg_hit(paddr, `TWM_IDX_TRN))  rd_value = transmit_byte;
    if (reg_hit(paddr, `TWM_IDX_BRG))  rd_value = bit_rate_reload;
    if (reg_hit(paddr, `TWM_IDX_CON))  rd_value = port_control;
    if (reg_hit(paddr, `TWM_IDX_STAT)) rd_value = port_status;
    if (reg_hit(paddr, `TWM_IDX_ADD))  rd_value = own_slave_address;
  end

  // Read data captured in the setup cycle so it comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= {16'h0000, rd_value};
    end
  end

endmodule // twm_master_engine

/* common/twm_map.svh */
// Register indices, field positions, reset values of the two-wire master
`ifndef TWM_MAP_SVH
`define TWM_MAP_SVH

// Register indices; byte address on APB is four times the index
`define TWM_IDX_RCV     10'h200
`define TWM_IDX_TRN     10'h202
`define TWM_IDX_BRG     10'h204
`define TWM_IDX_CON     10'h206
`define TWM_IDX_STAT    10'h208
`define TWM_IDX_ADD     10'h20A

// Reset values
`define TWM_RST_RCV     16'h0000
`define TWM_RST_TRN     16'h00FF
`define TWM_RST_BRG     16'h0000
`define TWM_RST_CON     16'h1000
`define TWM_RST_ADD     16'h0000

// Writable bits of port_control and own_slave_address
`define TWM_CON_MASK    16'hBFFF
`define TWM_ADD_MASK    16'h03FF

// port_control fields
`define TWM_CON_EN      15
`define TWM_CON_SIDL    13
`define TWM_CON_ACK_VALUE   5
`define TWM_CON_REQ_HI  4
`define TWM_CON_ACK_SEQUENCE_ENABLE   4
`define TWM_CON_MASTER_RECEIVE_ENABLE    3
`define TWM_CON_PEN     2
`define TWM_CON_RESTART_REQUEST    1
`define TWM_CON_SEN     0

// port_status fields
`define TWM_ST_ACKSTAT  15
`define TWM_ST_MASTER_TX_ACTIVE   14
`define TWM_ST_BCL      10
`define TWM_ST_P        4
`define TWM_ST_S        3
`define TWM_ST_RBF      1
`define TWM_ST_TBF      0

// Index of the last bit of one transfer
`define TWM_LAST_TX_BIT 4'd8
`define TWM_LAST_RX_BIT 4'd7

`endif

/* common/twm_pkg.sv */
// Types shared by the two-wire master engine
package twm_pkg;

  typedef enum logic [2:0] {
    TWM_IDLE,
    TWM_START,
    TWM_RESTART,
    TWM_STOP,
    TWM_TX,
    TWM_RX,
    TWM_ACK
  } twm_state_type;

  // One bit per bus line: a level, or a pull-low request
  typedef struct packed {
    logic scl;
    logic sda;
  } twm_line_type;

endpackage

/* verification/twm_master_engine_sva.sv */
// Port checker for the two-wire master engine
`timescale 1ns/1ps
module twm_master_engine_sva #(
  parameter int BRG_W = 12
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        scl_in,
  input wire logic        scl_out,
  input wire logic        scl_oe,
  input wire logic        sda_out,
  input wire logic        sda_oe,
  input wire logic        sleep_mode,
  input wire logic        master_event
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_open_drain;
    !scl_out && !sda_out;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("open-drain output driven high");

  property p_event_pulse;
    master_event |=> !master_event;
  endproperty
  a_event_pulse: assert property (p_event_pulse)
    else $error("master event longer than one cycle");

  property p_scl_stall;
    !scl_oe && !scl_in |=> !scl_oe;
  endproperty
  a_scl_stall: assert property (p_scl_stall)
    else $error("clock pulled while held low outside");

  property p_scl_high;
    $rose(scl_oe) |-> $past(scl_in, 1) && $past(scl_in, 2) && $past(scl_in, 3);
  endproperty
  a_scl_high: assert property (p_scl_high)
    else $error("clock high phase too short");

  property p_phase_min;
    disable iff (!presetn || sleep_mode)
    $changed(scl_oe) |=> $stable(scl_oe) [*2];
  endproperty
  a_phase_min: assert property (p_phase_min)
    else $error("clock phase shorter than count");

  property p_sleep_release;
    sleep_mode [*3] |-> !scl_oe && !sda_oe;
  endproperty
  a_sleep_release: assert property (p_sleep_release)
    else $error("lines still pulled in sleep");

  property p_sleep_quiet;
    sleep_mode [*2] |-> !master_event;
  endproperty
  a_sleep_quiet: assert property (p_sleep_quiet)
    else $error("master event during sleep");

  property p_misaligned;
    psel && penable && paddr[1:0] != 2'h0 |-> pslverr && pready;
  endproperty
  a_misaligned: assert property (p_misaligned)
    else $error("misaligned access not refused");
endmodule // twm_master_engine_sva

bind twm_master_engine twm_master_engine_sva #(.BRG_W(BRG_W)) i_sva (.*);

/* verification/twm_bus_partner.sv */
// Slave-side bus model: stretching, read data, forced collisions
`timescale 1ns/1ps
module twm_bus_partner (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       scl,
  input  wire logic [3:0] stretch,
  input  wire logic       grab_sda,
  input  wire logic       load,
  input  wire logic [7:0] rd_byte,
  output logic            scl_pull,
  output logic            sda_pull
);
  logic       scl_q;
  logic [3:0] hold;
  logic [7:0] shreg;

  // Holding low past the master's count forces a stall
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_q <= 1'b1;
      hold  <= 4'h0;
    end else begin
      scl_q <= scl;
      if (scl_q && !scl) begin
        hold <= stretch;
      end else if (hold != 4'h0) begin
        hold <= hold - 4'h1;
      end
    end
  end

  // Data moves only after a clock fall
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shreg <= 8'hFF;
    end else if (load) begin
      shreg <= rd_byte;
    end else if (scl_q && !scl) begin
      shreg <= {shreg[6:0], 1'b1};
    end
  end

  assign scl_pull = hold != 4'h0;
  assign sda_pull = !shreg[7] || grab_sda;
endmodule // twm_bus_partner

/* verification/tb_twm_master_engine.sv */
// Self-checking bench for the two-wire master engine
`timescale 1ns/1ps
module tb_twm_master_engine;
  localparam logic [11:0] A_RCV = 12'h800;
  localparam logic [11:0] A_TRN = 12'h808;
  localparam logic [11:0] A_BRG = 12'h810;
  localparam logic [11:0] A_CON = 12'h818;
  localparam logic [11:0] A_ST  = 12'h820;
  localparam logic [11:0] A_ADD = 12'h828;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        scl_oe;
  logic        sda_oe;
  logic        sleep_mode = 1'b0;
  logic        cpu_idle = 1'b0;
  logic        master_event;
  logic        scl_pull;
  logic        sda_pull;
  logic [3:0]  stretch = 4'h0;
  logic        grab_sda = 1'b0;
  logic        load = 1'b0;
  logic [7:0]  rd_byte = 8'h00;
  logic [7:0]  rb;
  logic [31:0] e_v;
  logic [31:0] m_v;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  int          fail_count = 0;
  int          check_count = 0;
  int          ev_count = 0;
  int          ev_seen;
  int          cycles = 0;
  // Pull-ups on both lines
  wire         scl = !(scl_oe || scl_pull);
  wire         sda = !(sda_oe || sda_pull);

  twm_master_engine #(.BRG_W(12)) i_twm_master_engine (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(), .scl_in(scl), .sda_in(sda),
    .scl_out(), .scl_oe(scl_oe), .sda_out(), .sda_oe(sda_oe),
    .sleep_mode(sleep_mode), .cpu_idle(cpu_idle),
    .master_event(master_event));

  twm_bus_partner i_twm_bus_partner (
    .pclk(pclk), .presetn(presetn), .scl(scl), .stretch(stretch),
    .grab_sda(grab_sda), .load(load), .rd_byte(rd_byte),
    .scl_pull(scl_pull), .sda_pull(sda_pull));

  always #5 pclk = ~pclk;

  task automatic finish_test;
    if (fail_count == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (master_event === 1'b1) ev_count <= ev_count + 1;
    if (psel && penable && !pwrite && pready === 1'b1) begin
      e_v = exp_q.pop_front();
      m_v = msk_q.pop_front();
      check_count++;
      if ((prdata & m_v) !== (e_v & m_v)) begin
        fail_count++;
        $display("unexpected %0t read %h got %h", $time, paddr, prdata);
      end
    end
    if (cycles == 20000) begin
      fail_count++;
      $display("unexpected %0t timeout", $time);
      finish_test();
    end
  end

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e,
                    input logic [31:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic wait_evt;
    int i;
    i = 0;
    check_count++;
    do begin
      @(posedge pclk);
      i++;
    end while (master_event !== 1'b1 && i < 3000);
    if (master_event !== 1'b1) begin
      fail_count++;
      $display("unexpected %0t no master event", $time);
    end
  endtask

  initial begin
    void'($urandom(6271));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd(A_RCV, 32'h0000, 32'hFFFFFFFF);
    rd(A_TRN, 32'h00FF, 32'hFFFFFFFF);
    rd(A_BRG, 32'h0000, 32'hFFFFFFFF);
    rd(A_CON, 32'h1000, 32'hFFFFFFFF);
    rd(A_ST, 32'h0000, 32'hFFFFFFFF);
    rd(A_ADD, 32'h0000, 32'hFFFFFFFF);
    rd(12'h802, 32'h0, 32'hFFFFFFFF);
    apb(1'b1, A_ADD, 32'hFFFF);
    apb(1'b1, A_RCV, 32'hFFFF);
    rd(A_ADD, 32'h03FF, 32'hFFFFFFFF);
    rd(A_RCV, 32'h0000, 32'hFFFFFFFF);
    apb(1'b1, A_BRG, 32'h0007);
    apb(1'b1, A_CON, 32'h8000);
    stretch <= 4'hC;
    apb(1'b1, A_CON, 32'h8001);
    wait_evt();
    apb(1'b1, A_TRN, 32'h00A5);
    rd(A_ST, 32'h4001, 32'h4001);
    apb(1'b1, A_CON, 32'h8008);
    wait_evt();
    rd(A_CON, 32'h0000, 32'h0008);
    rd(A_ST, 32'h8000, 32'hC001);
    rb = 8'($urandom);
    rd_byte <= rb;
    load <= 1'b1;
    @(posedge pclk);
    load <= 1'b0;
    apb(1'b1, A_CON, 32'h8008);
    wait_evt();
    rd(A_ST, 32'h0002, 32'h0002);
    rd(A_RCV, {24'h0, rb}, 32'hFFFFFFFF);
    rd(A_CON, 32'h8000, 32'h800F);
    apb(1'b1, A_CON, 32'h8010);
    wait_evt();
    rd(A_CON, 32'h0000, 32'h0010);
    apb(1'b1, A_CON, 32'h8004);
    wait_evt();
    rd(A_ST, 32'h0010, 32'h0018);
    apb(1'b1, A_TRN, 32'h00FF);
    grab_sda <= 1'b1;
    wait_evt();
    rd(A_ST, 32'h0400, 32'h4401);
    grab_sda <= 1'b0;
    wait_evt();
    apb(1'b1, A_ST, 32'h0000);
    rd(A_ST, 32'h0000, 32'h0400);
    apb(1'b1, A_TRN, 32'h005A);
    // Receive request while busy must not stick
    apb(1'b1, A_CON, 32'h8008);
    rd(A_CON, 32'h0000, 32'h0008);
    wait_evt();
    apb(1'b1, A_CON, 32'hA000);
    apb(1'b1, A_TRN, 32'h00C3);
    cpu_idle <= 1'b1;
    ev_seen = ev_count;
    repeat (300) @(posedge pclk);
    check_count++;
    if (ev_count !== ev_seen) begin
      fail_count++;
      $display("unexpected %0t event while halted in idle", $time);
    end
    cpu_idle <= 1'b0;
    wait_evt();
    apb(1'b1, A_TRN, 32'h00FF);
    repeat (40) @(posedge pclk);
    sleep_mode <= 1'b1;
    ev_seen = ev_count;
    repeat (6) @(posedge pclk);
    sleep_mode <= 1'b0;
    repeat (400) @(posedge pclk);
    check_count++;
    if (ev_count !== ev_seen) begin
      fail_count++;
      $display("unexpected %0t event after sleep abort", $time);
    end
    rd(A_ST, 32'h0000, 32'h4001);
    finish_test();
  end
endmodule // tb_twm_master_engine
